//--- rtl/pin_ctrl_top.sv
/*
 power, suspend, reset and status pin controller.
 assumes usb status strobes from logic on the same clock, pins asynchronous,
 and the pad ring resolving tristate pins from the enables (low = drive).
*/
module pin_ctrl_top #(
	parameter int unsigned RST_DELAY_CYC = pins_pkg::RST_DELAY_CYCLES
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_sys_rst,
	input  wire logic                    i_ext_rst_n,
	input  wire logic                    i_ring_indicator_n,
	input  wire logic                    i_power_source_select,
	input  wire logic                    i_cfg_mem_select,
	input  wire logic                    i_cfg_mem_data,
	input  wire logic                    i_mem_select_drv,
	input  wire logic                    i_mem_clock_drv,
	input  wire logic                    i_mem_data_drv,
	input  wire logic                    i_mem_data_drive_en,
	input  wire logic [pins_pkg::CFG_W-1:0] i_cfg_word,
	input  wire logic                    i_cfg_load,
	input  wire logic                    i_usb_suspend,
	input  wire logic                    i_usb_configured,
	input  wire logic                    i_usb_bus_reset,
	input  wire logic                    i_usb_tx_pulse,
	input  wire logic                    i_usb_rx_pulse,
	input  wire logic                    i_uart_tx_active,
	output logic                         o_resume_req,
	output logic                         o_clk_48m_sel,
	output logic                         o_cfg_mem_select,
	output logic                         o_cfg_mem_select_oe_n,
	output logic                         o_cfg_mem_clock,
	output logic                         o_cfg_mem_clock_oe_n,
	output logic                         o_cfg_mem_data,
	output logic                         o_cfg_mem_data_oe_n,
	output logic                         o_mem_data_in,
	output logic                         o_sleep_n,
	output logic                         o_power_enable_n,
	output logic                         o_bus_powered,
	output logic                         o_rst_out_n,
	output logic                         o_rst_out_oe_n,
	output logic                         o_tx_activity_led_n,
	output logic                         o_tx_activity_led_oe_n,
	output logic                         o_rx_activity_led_n,
	output logic                         o_rx_activity_led_oe_n,
	output logic                         o_osc_clock_out,
	output logic                         o_rs485_driver_enable,
	output logic                         o_remote_wake_en,
	output logic                         o_iso_mode,
	output logic                         o_pulldown_en,
	output logic                         o_usb2_desc
);
	localparam logic [pins_pkg::RST_CNT_W-1:0] DELAY_LAST =
		pins_pkg::RST_CNT_W'(RST_DELAY_CYC - 1);
	localparam logic [pins_pkg::LED_CNT_W-1:0] LED_LAST =
		pins_pkg::LED_CNT_W'(pins_pkg::LED_PULSE_CYCLES);
	localparam logic [pins_pkg::OSC_CNT_W-1:0] OSC_LAST =
		pins_pkg::OSC_CNT_W'(pins_pkg::OSC_HALF_CYCLES - 1);

	// synchronised pin levels
	logic ext_rst_n_s;   // external reset, low active
	logic ring_n_s;      // ring indicator, low active
	logic pwr_src_s;     // power source select
	logic cfg_sel_s;     // select line strap level
	logic cfg_data_s;    // memory data read back

	pin_sync3 #(.RESET_VAL(1'b1)) u_sync_rst (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_ext_rst_n), .o_level(ext_rst_n_s));
	pin_sync3 #(.RESET_VAL(1'b1)) u_sync_ring (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_ring_indicator_n), .o_level(ring_n_s));
	pin_sync3 #(.RESET_VAL(1'b0)) u_sync_pwr (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_power_source_select),
		.o_level(pwr_src_s));
	pin_sync3 #(.RESET_VAL(1'b1)) u_sync_sel (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_cfg_mem_select), .o_level(cfg_sel_s));
	pin_sync3 #(.RESET_VAL(1'b1)) u_sync_dat (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_cfg_mem_data), .o_level(cfg_data_s));

	// reset sequencer state
	pins_pkg::rst_state_t              rst_state_reg;
	pins_pkg::rst_state_t              rst_state_next;
	logic [pins_pkg::RST_CNT_W-1:0]    rst_cnt_reg;
	logic [pins_pkg::RST_CNT_W-1:0]    rst_cnt_next;
	logic                              core_run;      // device out of reset

	assign core_run = (rst_state_reg != pins_pkg::RST_HOLD);

	// sequencer: hold, count the delay, then run
	always_comb begin
		rst_state_next = rst_state_reg;
		rst_cnt_next   = rst_cnt_reg;
		if (!ext_rst_n_s) begin
			rst_state_next = pins_pkg::RST_HOLD;
			rst_cnt_next   = '0;
		end else begin
			case (rst_state_reg)
				pins_pkg::RST_HOLD: begin
					rst_state_next = pins_pkg::RST_WAIT;
					rst_cnt_next   = '0;
				end
				pins_pkg::RST_WAIT: begin
					if (rst_cnt_reg >= DELAY_LAST) begin
						rst_state_next = pins_pkg::RST_RUN;
					end else begin
						rst_cnt_next = rst_cnt_reg + 1'b1;
					end
				end
				pins_pkg::RST_RUN: begin
					rst_state_next = pins_pkg::RST_RUN;
				end
				default: begin
					rst_state_next = pins_pkg::RST_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rst_state_reg <= pins_pkg::RST_HOLD;
			rst_cnt_reg   <= '0;
		end else begin
			rst_state_reg <= rst_state_next;
			rst_cnt_reg   <= rst_cnt_next;
		end
	end

	// strap capture and option registers
	logic                        strap_taken_reg, strap_taken_next;
	logic                        clk48_reg, clk48_next;
	logic [pins_pkg::CFG_W-1:0]  cfg_reg, cfg_next;
	logic                        strap_take;   // last delay cycle, synchroniser long settled

	// strap read late so the pull-up reset value of the sync chain has flushed out
	assign strap_take = !strap_taken_reg && (rst_state_reg == pins_pkg::RST_WAIT) &&
		(rst_cnt_reg >= DELAY_LAST);

	always_comb begin
		strap_taken_next = strap_taken_reg;
		clk48_next       = clk48_reg;
		cfg_next         = cfg_reg;
		if (!core_run) begin
			strap_taken_next = 1'b0;
			cfg_next         = pins_pkg::CFG_RESET;
		end else begin
			// sample strap while pins still float
			if (strap_take) begin
				clk48_next       = !cfg_sel_s;
				strap_taken_next = 1'b1;
			end
			if (i_cfg_load) begin
				cfg_next = i_cfg_word;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			strap_taken_reg <= 1'b0;
			clk48_reg       <= 1'b0;
			cfg_reg         <= pins_pkg::CFG_RESET;
		end else begin
			strap_taken_reg <= strap_taken_next;
			clk48_reg       <= clk48_next;
			cfg_reg         <= cfg_next;
		end
	end

	// usb power state
	logic configured_reg, configured_next;
	logic ring_prev_reg, ring_prev_next;
	logic ring_fall;
	logic wake_ok;

	assign ring_fall = ring_prev_reg && !ring_n_s;
	assign wake_ok = cfg_reg[pins_pkg::CFG_WAKE_BIT] && i_usb_suspend && core_run;

	always_comb begin
		configured_next = configured_reg;
		ring_prev_next  = ring_n_s;
		// set wins over bus reset clear
		if (!core_run) begin
			configured_next = 1'b0;
		end else if (i_usb_configured) begin
			configured_next = 1'b1;
		end else if (i_usb_bus_reset) begin
			configured_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			configured_reg <= 1'b0;
			ring_prev_reg  <= 1'b1;
		end else begin
			configured_reg <= configured_next;
			ring_prev_reg  <= ring_prev_next;
		end
	end

	// activity led stretchers, one per channel
	logic [pins_pkg::LED_N-1:0] led_act;
	logic [pins_pkg::LED_N-1:0] led_oe_n_reg;

	assign led_act[pins_pkg::LED_TX] = i_usb_tx_pulse;
	assign led_act[pins_pkg::LED_RX] = i_usb_rx_pulse;

	genvar g;
	generate
		for (g = 0; g < pins_pkg::LED_N; g++) begin : g_led
			logic [pins_pkg::LED_CNT_W-1:0] cnt_reg, cnt_next;
			always_comb begin
				cnt_next = cnt_reg;
				if (!core_run) begin
					cnt_next = '0;
				end else if (led_act[g]) begin
					cnt_next = LED_LAST;
				end else if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					cnt_reg         <= '0;
					led_oe_n_reg[g] <= 1'b1;
				end else begin
					cnt_reg         <= cnt_next;
					led_oe_n_reg[g] <= (cnt_next == '0);
				end
			end
		end
	endgenerate

	// oscillator output divider
	logic [pins_pkg::OSC_CNT_W-1:0] osc_cnt_reg, osc_cnt_next;
	logic                           osc_reg, osc_next;

	always_comb begin
		osc_cnt_next = osc_cnt_reg + 1'b1;
		osc_next     = osc_reg;
		if (!core_run || i_usb_suspend) begin
			osc_cnt_next = '0;
			osc_next     = 1'b0;
		end else if (osc_cnt_reg >= OSC_LAST) begin
			osc_cnt_next = '0;
			osc_next     = !osc_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			osc_cnt_reg <= '0;
			osc_reg     <= 1'b0;
		end else begin
			osc_cnt_reg <= osc_cnt_next;
			osc_reg     <= osc_next;
		end
	end

	// registered pin outputs
	logic mem_drive;   // memory pins released to the reader

	// float in reset, drive after strap
	assign mem_drive = core_run && strap_taken_reg;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_resume_req          <= 1'b0;
			o_cfg_mem_select      <= 1'b0;
			o_cfg_mem_select_oe_n <= 1'b1;
			o_cfg_mem_clock       <= 1'b0;
			o_cfg_mem_clock_oe_n  <= 1'b1;
			o_cfg_mem_data        <= 1'b0;
			o_cfg_mem_data_oe_n   <= 1'b1;
			o_mem_data_in         <= 1'b1;
			o_sleep_n             <= 1'b1;
			o_power_enable_n      <= 1'b1;
			o_bus_powered         <= 1'b1;
			o_rst_out_oe_n        <= 1'b1;
			o_rs485_driver_enable <= 1'b0;
		end else begin
			// resume pulse on ring falling edge
			o_resume_req          <= ring_fall && wake_ok;
			o_cfg_mem_select      <= i_mem_select_drv;
			o_cfg_mem_select_oe_n <= !mem_drive;
			o_cfg_mem_clock       <= i_mem_clock_drv;
			o_cfg_mem_clock_oe_n  <= !mem_drive;
			o_cfg_mem_data        <= i_mem_data_drv;
			o_cfg_mem_data_oe_n   <= !(mem_drive && i_mem_data_drive_en);
			o_mem_data_in         <= cfg_data_s;
			o_sleep_n             <= !(core_run && i_usb_suspend);
			o_power_enable_n      <= !(configured_reg && !i_usb_suspend);
			o_bus_powered         <= !pwr_src_s;
			// drive once the delay has run
			o_rst_out_oe_n        <= (rst_state_reg != pins_pkg::RST_RUN);
			o_rs485_driver_enable <= core_run && i_uart_tx_active;
		end
	end

	assign o_clk_48m_sel          = clk48_reg;
	assign o_rst_out_n            = 1'b1;
	assign o_tx_activity_led_n    = 1'b0;
	assign o_rx_activity_led_n    = 1'b0;
	assign o_tx_activity_led_oe_n = led_oe_n_reg[pins_pkg::LED_TX];
	assign o_rx_activity_led_oe_n = led_oe_n_reg[pins_pkg::LED_RX];
	assign o_osc_clock_out        = osc_reg;
	assign o_remote_wake_en       = cfg_reg[pins_pkg::CFG_WAKE_BIT];
	assign o_iso_mode             = cfg_reg[pins_pkg::CFG_ISO_BIT];
	assign o_pulldown_en          = cfg_reg[pins_pkg::CFG_PULLDN_BIT];
	assign o_usb2_desc            = cfg_reg[pins_pkg::CFG_USB2_BIT];

	// checks on the pin behaviour
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_wake_resume: assert property (ring_fall && wake_ok |=> o_resume_req)
		else $error("ring edge did not raise resume");
	a_wake_ignored: assert property (o_resume_req |-> $past(wake_ok))
		else $error("resume without enable and suspend");
	a_strap_sample: assert property (strap_take |=>
		o_clk_48m_sel == !$past(cfg_sel_s))
		else $error("clock strap sampled wrongly");
	a_mem_float: assert property (!core_run |=>
		o_cfg_mem_clock_oe_n && o_cfg_mem_data_oe_n && o_cfg_mem_select_oe_n)
		else $error("memory pins driven in reset");
	a_mem_clock_drive: assert property (mem_drive |=> !o_cfg_mem_clock_oe_n)
		else $error("memory clock not driven after reset");
	a_sleep_level: assert property (core_run && i_usb_suspend |=> !o_sleep_n)
		else $error("sleep not low in suspend");
	a_power_suspend: assert property (i_usb_suspend |=> o_power_enable_n)
		else $error("power enabled during suspend");
	a_power_config: assert property (i_usb_configured && core_run &&
		!i_usb_suspend ##1 !i_usb_suspend |=> !o_power_enable_n)
		else $error("power not enabled when configured");
	a_power_deconf: assert property (i_usb_bus_reset && !i_usb_configured
		|=> ##1 o_power_enable_n)
		else $error("power enabled after bus reset");
	a_source_sel: assert property (##1 o_bus_powered == !$past(pwr_src_s))
		else $error("power source sense wrong");
	a_release_delay: assert property (rst_state_reg == pins_pkg::RST_RUN &&
		$past(rst_state_reg) == pins_pkg::RST_WAIT |-> $past(rst_cnt_reg) == DELAY_LAST)
		else $error("reset output released early");
	a_ext_float: assert property (!ext_rst_n_s |-> ##2 o_rst_out_oe_n)
		else $error("reset output driven under external reset");
	a_busrst_keep: assert property (rst_state_reg == pins_pkg::RST_RUN &&
		ext_rst_n_s && i_usb_bus_reset |=> rst_state_reg == pins_pkg::RST_RUN)
		else $error("bus reset touched reset output");
	a_rst_drive: assert property (rst_state_reg == pins_pkg::RST_RUN
		|=> !o_rst_out_oe_n && o_rst_out_n)
		else $error("reset output not driven");
	a_tx_led: assert property (core_run && i_usb_tx_pulse |=> !o_tx_activity_led_oe_n)
		else $error("tx led did not pulse");
	a_rx_led: assert property (core_run && i_usb_rx_pulse |=> !o_rx_activity_led_oe_n)
		else $error("rx led did not pulse");
	a_osc_stop: assert property (i_usb_suspend |=> !o_osc_clock_out)
		else $error("oscillator running in suspend");
	a_rs485_en: assert property (core_run && i_uart_tx_active |=> o_rs485_driver_enable)
		else $error("driver enable missing");
	a_cfg_load: assert property (core_run && i_cfg_load |=>
		o_remote_wake_en == $past(i_cfg_word[pins_pkg::CFG_WAKE_BIT]))
		else $error("option word not taken");

	c_resume: cover property (o_resume_req);
	c_release: cover property (rst_state_reg == pins_pkg::RST_WAIT ##1
		rst_state_reg == pins_pkg::RST_RUN);
	c_power_on: cover property (!o_power_enable_n ##1 i_usb_suspend);
	c_led: cover property (!o_tx_activity_led_oe_n && !o_rx_activity_led_oe_n);
endmodule

//--- shared/pins_pkg.sv
/*
 shared constants for the power, reset and status pin controller.
 assumes a 100 MHz system clock and a synchronous active-high reset.
*/
package pins_pkg;
	// clock and timing figures
	localparam int unsigned CLK_FREQ_KHZ     = 100000;
	localparam int unsigned RST_DELAY_US     = 2000;
	localparam int unsigned RST_DELAY_CYCLES = RST_DELAY_US * (CLK_FREQ_KHZ / 1000);
	localparam int unsigned LED_PULSE_US     = 10;
	localparam int unsigned LED_PULSE_CYCLES = LED_PULSE_US * (CLK_FREQ_KHZ / 1000);
	localparam int unsigned OSC_FREQ_KHZ     = 6000;
	localparam int unsigned OSC_HALF_CYCLES  = CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
	// counter widths
	localparam int unsigned RST_CNT_W = 18;
	localparam int unsigned LED_CNT_W = 10;
	localparam int unsigned OSC_CNT_W = 4;
	// configuration word layout
	localparam int unsigned CFG_W          = 4;
	localparam int unsigned CFG_WAKE_BIT   = 0;
	localparam int unsigned CFG_ISO_BIT    = 1;
	localparam int unsigned CFG_PULLDN_BIT = 2;
	localparam int unsigned CFG_USB2_BIT   = 3;
	localparam logic [3:0]  CFG_RESET      = 4'h0;
	// led channel indices
	localparam int unsigned LED_TX = 0;
	localparam int unsigned LED_RX = 1;
	localparam int unsigned LED_N  = 2;
	// reset sequencer states
	typedef enum logic [1:0] {
		RST_HOLD = 2'b00,
		RST_WAIT = 2'b01,
		RST_RUN  = 2'b10
	} rst_state_t;
endpackage

//--- rtl/pin_sync3.sv
/*
 three-stage pin synchroniser with agreement filter.
 assumes an asynchronous pin input and the system clock domain.
*/
module pin_sync3 #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_pin,
	output logic      o_level
);
	logic ff1_reg;   // first stage, read only by second
	logic ff2_reg;   // second stage
	logic ff3_reg;   // third stage
	logic lvl_reg;   // filtered level
	logic lvl_next;

	// level follows once stages two and three agree
	always_comb begin
		lvl_next = lvl_reg;
		if (ff2_reg == ff3_reg) begin
			lvl_next = ff3_reg;
		end
	end

	// register the chain
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ff1_reg <= RESET_VAL;
			ff2_reg <= RESET_VAL;
			ff3_reg <= RESET_VAL;
			lvl_reg <= RESET_VAL;
		end else begin
			ff1_reg <= i_pin;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign o_level = lvl_reg;
endmodule

//--- testbench/usb_host_model.sv
/*
 behavioural stand-in for the usb host and the suspend logic facing the pin controller.
 assumes one system clock; the bench asks for suspend by level, the model answers resumes.
*/
module usb_host_model #(
	parameter int unsigned WAKE_CYC = 3
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_want_suspend,
	input  wire logic i_resume_req,
	output logic      o_usb_suspend
);
	timeunit 1ns;
	timeprecision 1ps;

	int   wake_cnt;  // cycles left until the host ends suspend
	logic woke;      // host resumed; stays awake until the bench drops its request

	// suspend follows the bench, unless the host was woken by a resume request
	// power switching: the bench sets the pull-down option whenever it loads options
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_usb_suspend <= 1'b0;
			wake_cnt      <= 0;
			woke          <= 1'b0;
		end else begin
			if (i_resume_req && o_usb_suspend && wake_cnt == 0) begin
				wake_cnt <= WAKE_CYC;
			end else if (wake_cnt == 1) begin
				wake_cnt <= 0;
				woke     <= 1'b1;
			end else if (wake_cnt > 1) begin
				wake_cnt <= wake_cnt - 1;
			end
			if (!i_want_suspend) begin
				woke <= 1'b0;
			end
			o_usb_suspend <= i_want_suspend && !woke && !(wake_cnt == 1);
		end
	end
endmodule

//--- testbench/usb_serial_power_reset_pins_test.sv
/*
 self-checking bench for the power, suspend, reset and status pin controller.
 assumes the host model above and a shortened reset-output delay of 20 cycles.
*/
module usb_serial_power_reset_pins_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned DLY = 20;  // shortened reset-output delay
	logic clk = 0, sys_rst = 1, ext_rst_n = 1, ring_n = 1, pwr_sel = 0, strap = 0;
	logic data_pin = 1, sel_drv = 0, clk_drv = 0, data_drv = 0, data_en = 0;
	logic [pins_pkg::CFG_W-1:0] cfg_word = '0;
	logic cfg_load = 0, want_susp = 0, usb_susp, configured = 0, bus_rst = 0;
	logic tx_p = 0, rx_p = 0, uart_tx = 0;
	logic resume, clk48, mclk, mclk_oe_n, msel_oe_n, mdat_oe_n, sleep_n, pwr_n, bus_pwr;
	logic rst_n, rst_oe_n, txl_n, txl_oe_n, rxl_n, rxl_oe_n, osc, rs485;
	logic msel, mdat, mdin;  // memory select and data outputs, data pin read back
	logic [3:0] opts;  // wake, iso, pull-down, usb2 option outputs
	int   err_count = 0;
	int   n_checks = 0;

	// 100 MHz system clock
	always #5 clk = ~clk;

	pin_ctrl_top #(.RST_DELAY_CYC(DLY)) i_pin_ctrl_top (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_ext_rst_n(ext_rst_n),
		.i_ring_indicator_n(ring_n), .i_power_source_select(pwr_sel),
		.i_cfg_mem_select(strap), .i_cfg_mem_data(data_pin), .i_mem_select_drv(sel_drv),
		.i_mem_clock_drv(clk_drv), .i_mem_data_drv(data_drv), .i_mem_data_drive_en(data_en),
		.i_cfg_word(cfg_word), .i_cfg_load(cfg_load), .i_usb_suspend(usb_susp),
		.i_usb_configured(configured), .i_usb_bus_reset(bus_rst), .i_usb_tx_pulse(tx_p),
		.i_usb_rx_pulse(rx_p), .i_uart_tx_active(uart_tx), .o_resume_req(resume),
		.o_clk_48m_sel(clk48), .o_cfg_mem_select(msel), .o_cfg_mem_select_oe_n(msel_oe_n),
		.o_cfg_mem_clock(mclk), .o_cfg_mem_clock_oe_n(mclk_oe_n), .o_cfg_mem_data(mdat),
		.o_cfg_mem_data_oe_n(mdat_oe_n), .o_mem_data_in(mdin), .o_sleep_n(sleep_n),
		.o_power_enable_n(pwr_n), .o_bus_powered(bus_pwr), .o_rst_out_n(rst_n),
		.o_rst_out_oe_n(rst_oe_n), .o_tx_activity_led_n(txl_n),
		.o_tx_activity_led_oe_n(txl_oe_n), .o_rx_activity_led_n(rxl_n),
		.o_rx_activity_led_oe_n(rxl_oe_n), .o_osc_clock_out(osc), .o_rs485_driver_enable(rs485),
		.o_remote_wake_en(opts[0]), .o_iso_mode(opts[1]), .o_pulldown_en(opts[2]),
		.o_usb2_desc(opts[3]));

	usb_host_model i_usb_host_model (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_want_suspend(want_susp),
		.i_resume_req(resume), .o_usb_suspend(usb_susp));

	// compare a single design bit
	task automatic chk(input string nm, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %b seen %b", nm, exp, got);
			err_count++;
		end
	endtask

	// compare a cycle count against a window
	task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi) begin
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
			err_count++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// cycles until the reset output is driven again
	task automatic wait_run(output int n);
		n = 0;
		while (rst_oe_n !== 1'b0 && n < 80) begin
			cyc(1);
			n++;
		end
	endtask

	// power-up: floating pins, delayed reset output, 48 MHz strap
	task automatic t_boot;
		int n;
		cyc(8);
		chk("rst_oe_n in reset", 1'b1, rst_oe_n);
		chk("mem clk oe in reset", 1'b1, mclk_oe_n);
		chk("mem sel oe in reset", 1'b1, msel_oe_n);
		chk("mem dat oe in reset", 1'b1, mdat_oe_n);
		sys_rst = 0;
		wait_run(n);
		chk_rng("reset out delay", DLY, DLY + 6, n);
		chk("rst_out level", 1'b1, rst_n);
		chk("mem clk driven", 1'b0, mclk_oe_n);
		chk("strap 48m", 1'b1, clk48);
	endtask

	// external reset floats outputs; 6 MHz strap; usb bus reset ignored
	task automatic t_ext_reset;
		int n;
		ext_rst_n = 0;
		n = 0;
		while (rst_oe_n !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk_rng("ext reset float", 1, 8, n);
		strap = 1;
		cyc(30);
		chk("rst float held", 1'b1, rst_oe_n);
		chk("mem clk float", 1'b1, mclk_oe_n);
		ext_rst_n = 1;
		wait_run(n);
		chk_rng("reset out redelay", DLY, DLY + 10, n);
		chk("strap 6m", 1'b0, clk48);
		bus_rst = 1;
		cyc(3);
		bus_rst = 0;
		for (int i = 0; i < 10; i++) begin
			cyc(1);
			chk("bus reset no effect", 1'b0, rst_oe_n);
		end
	endtask

	// configure, suspend, resume, deconfigure
	task automatic t_power;
		bit hi = 0;
		chk("power off unconfig", 1'b1, pwr_n);
		configured = 1;
		cyc(1);
		chk("power not yet", 1'b1, pwr_n);
		configured = 0;
		cyc(1);
		chk("power on configured", 1'b0, pwr_n);
		chk("sleep high awake", 1'b1, sleep_n);
		want_susp = 1;
		cyc(3);
		chk("sleep low suspend", 1'b0, sleep_n);
		chk("power off suspend", 1'b1, pwr_n);
		for (int i = 0; i < 20; i++) begin
			cyc(1);
			chk("osc stopped", 1'b0, osc);
		end
		want_susp = 0;
		cyc(3);
		chk("power back", 1'b0, pwr_n);
		chk("sleep back", 1'b1, sleep_n);
		for (int i = 0; i < 20; i++) begin
			cyc(1);
			hi |= (osc === 1'b1);
		end
		chk("osc runs", 1'b1, hi);
		bus_rst = 1;
		cyc(1);
		bus_rst = 0;
		cyc(3);
		chk("power off bus reset", 1'b1, pwr_n);
	endtask

	// load an option word and check all four option outputs
	task automatic load_opts(input logic [3:0] w);
		cfg_word = w;
		cfg_load = 1;
		cyc(1);
		cfg_load = 0;
		cyc(1);
		for (int b = 0; b < 4; b++) begin
			chk("option bit", w[b], opts[b]);
		end
	endtask

	// pull the ring line low once and watch for a resume pulse
	task automatic ring_try(input logic exp);
		bit seen = 0;
		ring_n = 0;
		repeat (12) begin
			cyc(1);
			seen |= (resume === 1'b1);
		end
		ring_n = 1;
		cyc(6);
		chk("resume pulse", exp, seen);
	endtask

	// remote wake enabled, disabled and outside suspend
	task automatic t_wake;
		load_opts(4'hF);
		load_opts(4'h5);
		want_susp = 1;
		cyc(4);
		ring_try(1'b1);
		chk("host woke", 1'b0, usb_susp);
		want_susp = 0;
		load_opts(4'h4);
		want_susp = 1;
		cyc(4);
		ring_try(1'b0);
		want_susp = 0;
		load_opts(4'h5);
		cyc(4);
		ring_try(1'b0);
	endtask

	// one usb transfer lights its led for the pulse length only
	task automatic led_try(input bit rx);
		if (rx) rx_p = 1;
		else tx_p = 1;
		cyc(1);
		{rx_p, tx_p} = 2'b00;
		cyc(1);
		chk("led on", 1'b0, rx ? rxl_oe_n : txl_oe_n);
		chk("other led off", 1'b1, rx ? txl_oe_n : rxl_oe_n);
		chk("led pin low", 1'b0, rx ? rxl_n : txl_n);
		cyc(pins_pkg::LED_PULSE_CYCLES - 10);
		chk("led still on", 1'b0, rx ? rxl_oe_n : txl_oe_n);
		cyc(20);
		chk("led off", 1'b1, rx ? rxl_oe_n : txl_oe_n);
	endtask

	// power source, rs485 enable and memory pin drive
	task automatic t_misc;
		for (int v = 0; v < 2; v++) begin
			pwr_sel = v[0];
			uart_tx = v[0];
			clk_drv = v[0];
			sel_drv = v[0];
			data_drv = v[0];
			data_pin = v[0];
			data_en = 1;
			cyc(6);
			chk("mem select out", v[0], msel);
			chk("mem data out", v[0], mdat);
			chk("mem data read back", v[0], mdin);
			chk("bus powered", !v[0], bus_pwr);
			chk("rs485 enable", v[0], rs485);
			chk("mem clock out", v[0], mclk);
			chk("mem data drive", 1'b0, mdat_oe_n);
		end
	endtask

	// verdict and end of run
	task automatic test_done;
		if (err_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// main sequence
	// test input held grounded: the block offers no test-mode port
	initial begin
		t_boot;
		t_ext_reset;
		t_power;
		t_wake;
		led_try(1'b0);
		led_try(1'b1);
		t_misc;
		test_done;
	end

	// watchdog: the whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done;
	end
endmodule
